// ---- pkg/pmr_map.vh ----
`ifndef PMR_MAP_VH
`define PMR_MAP_VH
// status byte field positions
`define PMR_ST_DIG_OC       0
`define PMR_ST_CONV_ALERT   1
`define PMR_ST_SW_OC        2
`define PMR_ST_SW_FAIL      3
`define PMR_ST_OFF_STATUS   4
`define PMR_ST_OFF_ALERT    5
// readback mode codes
`define PMR_MODE_BOTH       2'h0
`define PMR_MODE_VOLT       2'h1
`define PMR_MODE_CURR       2'h2
// frame lengths in bytes
`define PMR_LEN_BOTH        2'h3
`define PMR_LEN_SINGLE      2'h2
`define PMR_LEN_STATUS      2'h1
// conversions that must reach or exceed the threshold in a row
`define PMR_OC_RUN          2'h3
// reset values
`define PMR_STATUS_RST      8'h00
`define PMR_ADDR_DEFAULT    7'h40
`endif

// ---- hdl/pmr_frame_mem.v ----
`timescale 1ns/1ps
`default_nettype none
// frame store of 1<<AW bytes (four by default), read data registered
module pmr_frame_mem #(
  parameter AW = 2,
  parameter DW = 8
) (
  input  wire          ref_clk,   // system clock
  input  wire          reset,     // async reset, active high
  input  wire          wr_en,     // write strobe
  input  wire [AW-1:0] wr_addr,   // write index
  input  wire [DW-1:0] wr_data,   // write data
  input  wire [AW-1:0] rd_addr,   // read index
  output reg  [DW-1:0] rd_data    // registered read data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // storage write
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data <= {DW{1'b0}};
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // pmr_frame_mem
`default_nettype wire

// ---- hdl/pmr_readback.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pmr_map.vh"
module pmr_readback #(
  parameter [6:0] DEV_ADDR = `PMR_ADDR_DEFAULT, // arbitrary default address
  parameter       CW       = 12                 // conversion code width
) (
  input  wire          ref_clk,            // 200 MHz system clock
  input  wire          reset,              // async reset, active high
  input  wire          scl_in,             // serial clock pin
  input  wire          sda_in,             // serial data pin level
  output reg           sda_out,            // serial data drive value
  output reg           sda_oe,             // high while pulling data low
  input  wire [CW-1:0] volt_code,          // voltage conversion result
  input  wire [CW-1:0] curr_code,          // current conversion result
  input  wire          volt_valid,         // one-cycle pulse: new voltage result
  input  wire          curr_valid,         // one-cycle pulse: new current result
  input  wire [1:0]    readback_mode,      // both, voltage or current
  input  wire          single_shot,        // conversion is single-shot
  input  wire          status_read_sel,    // return status byte
  input  wire [7:0]    alert_threshold_reg,// compared to current bits 11..4
  input  wire          conv_alert_enable,  // conversion overcurrent alert enable
  input  wire          switch_off_overcurrent, // switch held off by analog trip
  input  wire          latch_off_variant,  // part latches off instead of retrying
  input  wire          switch_fail_event,  // pulse: hot-swap operation failed
  input  wire          switch_fail_alert_enable, // enables switch fail alert
  input  wire          on_off_input_pin,   // on/off pin, high = asserted
  input  wire          software_switch_off,// software off control bit
  input  wire          off_alert_enable,   // enables switch-off alert
  input  wire          alert_clear_wr,     // pulse: clear bit written high
  output reg           alert_clear_bit,    // clear bit readback, self-clears
  output reg  [7:0]    alert_status        // status byte
);
  // one-hot states of the serial engine
  localparam ST_IDLE = 6'h01;
  localparam ST_ADDR = 6'h02;
  localparam ST_AACK = 6'h04;
  localparam ST_SEND = 6'h08;
  localparam ST_MACK = 6'h10;
  localparam ST_SKIP = 6'h20;

  // upper byte of a code
  function [7:0] hi8;
    input [CW-1:0] c;
    begin
      hi8 = c[CW-1:CW-8];
    end
  endfunction

  // lower nibble of a code, zero padded below
  function [7:0] lo_pad;
    input [CW-1:0] c;
    begin
      lo_pad = {c[3:0], 4'h0};
    end
  endfunction

  // bytes in a read frame for the selected readback
  function [1:0] frame_len;
    input       st_sel;
    input [1:0] mode;
    begin
      frame_len = st_sel ? `PMR_LEN_STATUS :
                  (mode == `PMR_MODE_BOTH) ? `PMR_LEN_BOTH : `PMR_LEN_SINGLE;
    end
  endfunction

  // pin samplers, engine, frame and alert state
  reg [1:0]  scl_s_q, sda_s_q;
  reg        scl_p_q, sda_p_q;
  reg [1:0]  on_s_q;
  reg [5:0]  state_q;
  reg [3:0]  bit_q;
  reg [7:0]  sh_q;
  reg [1:0]  idx_q;
  reg [1:0]  len_q;
  reg        have_v_q, have_i_q;
  reg [1:0]  oc_run_q;
  reg        conv_alert_q, fail_q, off_alert_q, off_prev_q;
  reg        wr_en;
  reg [1:0]  wr_addr;
  reg [7:0]  wr_data;
  reg [1:0]  rd_addr;
  wire [7:0] rd_data;

  // two-flop synchronisers on the pins
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      on_s_q  <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      on_s_q  <= {on_s_q[0], on_off_input_pin};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end

  wire scl    = scl_s_q[1];
  wire sda    = sda_s_q[1];
  wire scl_r  = scl & ~scl_p_q;
  wire scl_f  = ~scl & scl_p_q;
  wire start  = scl & scl_p_q & sda_p_q & ~sda;
  wire stop   = scl & scl_p_q & ~sda_p_q & sda;
  wire off_now = ~on_s_q[1] | software_switch_off;
  wire data_ready = (readback_mode == `PMR_MODE_CURR) ? have_i_q :
                    (readback_mode == `PMR_MODE_VOLT) ? have_v_q :
                    (have_v_q & have_i_q);

  // threshold compare and the conversion that completes a three-run trip
  wire oc_over = hi8(curr_code) >= alert_threshold_reg;
  wire oc_trip = curr_valid & oc_over & (oc_run_q >= 2'h2);

  // frame assembly: codes are stored whole, zeros before first result
  always @* begin
    wr_en   = 1'b1;
    wr_addr = 2'h0;
    wr_data = 8'h00;
    if (status_read_sel) begin
      wr_data = alert_status;
    end else begin
      case (readback_mode)
        `PMR_MODE_VOLT: begin
          wr_addr = idx_q;
          wr_data = (idx_q == 2'h0) ? hi8(volt_code) :
                    (idx_q == 2'h1) ? lo_pad(volt_code) : 8'h00;
        end
        `PMR_MODE_CURR: begin
          wr_addr = idx_q;
          wr_data = (idx_q == 2'h0) ? hi8(curr_code) :
                    (idx_q == 2'h1) ? lo_pad(curr_code) : 8'h00;
        end
        default: begin
          wr_addr = idx_q;
          wr_data = (idx_q == 2'h0) ? hi8(volt_code) :
                    (idx_q == 2'h1) ? hi8(curr_code) :
                    {volt_code[3:0], curr_code[3:0]};
        end
      endcase
      if (!data_ready) begin
        wr_data = 8'h00;
      end
    end
    rd_addr = idx_q;
  end

  pmr_frame_mem #(.AW(2), .DW(8)) u_mem (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // result arrival tracking
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      have_v_q <= 1'b0;
      have_i_q <= 1'b0;
      oc_run_q <= 2'h0;
    end else begin
      if (volt_valid) begin
        have_v_q <= 1'b1;
      end
      if (curr_valid) begin
        have_i_q <= 1'b1;
        if (oc_over) begin
          oc_run_q <= (oc_run_q == `PMR_OC_RUN) ? oc_run_q : oc_run_q + 2'h1;
        end else begin
          oc_run_q <= 2'h0;
        end
      end
    end
  end

  // alert status: set wins over clear
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      conv_alert_q    <= 1'b0;
      fail_q          <= 1'b0;
      off_alert_q     <= 1'b0;
      off_prev_q      <= 1'b0;
      alert_clear_bit <= 1'b0;
      alert_status    <= `PMR_STATUS_RST;
    end else begin
      off_prev_q      <= off_now;
      alert_clear_bit <= alert_clear_wr;
      conv_alert_q <= (conv_alert_q & ~alert_clear_wr) |
                      (conv_alert_enable & oc_trip);
      fail_q       <= (fail_q & ~alert_clear_wr) |
                      (switch_fail_alert_enable & switch_fail_event);
      off_alert_q  <= (off_alert_q & ~alert_clear_wr) |
                      (off_alert_enable & off_now & ~off_prev_q);
      alert_status <= {2'h0,
                       off_alert_q,
                       off_now,
                       fail_q,
                       latch_off_variant ? fail_q : switch_off_overcurrent,
                       conv_alert_q,
                       oc_run_q == `PMR_OC_RUN};
    end
  end

  // serial slave engine
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      idx_q   <= 2'h0;
      len_q   <= `PMR_LEN_BOTH;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (start) begin
      state_q <= ST_ADDR;
      bit_q   <= 4'h0;
      idx_q   <= 2'h0;
      sda_oe  <= 1'b0;
    end else if (stop) begin
      state_q <= ST_IDLE;
      sda_oe  <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (scl_r) begin
            sh_q  <= {sh_q[6:0], sda};
            bit_q <= bit_q + 4'h1;
          end else if (scl_f && bit_q == 4'h8) begin
            if (sh_q == {DEV_ADDR, 1'b1} && !(single_shot && !data_ready)) begin
              sda_oe  <= 1'b1;
              state_q <= ST_AACK;
              len_q   <= frame_len(status_read_sel, readback_mode);
            end else begin
              state_q <= ST_SKIP;
            end
          end
        end
        ST_AACK: begin
          if (scl_f) begin
            sh_q    <= rd_data;
            sda_oe  <= ~rd_data[7];
            bit_q   <= 4'h1;
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (scl_f) begin
            if (bit_q == 4'h8) begin
              sda_oe  <= 1'b0;
              bit_q   <= 4'h0;
              idx_q   <= (idx_q + 2'h1 == len_q) ? 2'h0 : idx_q + 2'h1;
              state_q <= ST_MACK;
            end else begin
              sda_oe <= ~sh_q[6];
              sh_q   <= {sh_q[6:0], 1'b0};
              bit_q  <= bit_q + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_r) begin
            state_q <= sda ? ST_SKIP : ST_AACK;
          end
        end
        ST_SKIP: begin
          sda_oe <= 1'b0;
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule // pmr_readback
`default_nettype wire

// ---- dv/pmr_i2c_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-wire master: drives the clock, only ever pulls data low
module pmr_i2c_master (
  input  wire logic clk,   // system clock
  input  wire logic sda,   // resolved data line, pulled up
  output var  logic scl,   // serial clock
  output var  logic pull   // high pulls data low
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // quarter of a bit period
  task automatic qw();
    repeat (10) @(negedge clk);
  endtask
  // one bit: data set while clock low, sampled mid-high
  task automatic bit_x(input logic d, output logic q);
    pull = !d;
    qw();
    scl = 1'b1;
    qw();
    q = sda;
    qw();
    scl = 1'b0;
    qw();
  endtask
  // start, address with read bit, n bytes, last one refused, stop
  task automatic xfer(input logic [6:0] a, input int n, output logic acked, output logic [23:0] b);
    logic       q;
    logic [7:0] by;
    logic [7:0] ab;
    ab = {a, 1'b1};
    b = 24'h000000;
    qw();
    pull = 1'b1;
    qw();
    scl = 1'b0;
    qw();
    for (int i = 7; i >= 0; i--) bit_x(ab[i], q);
    bit_x(1'b1, q);
    acked = !q;
    for (int k = 0; k < n && acked; k++) begin
      for (int i = 7; i >= 0; i--) bit_x(1'b1, by[i]);
      b = {b[15:0], by};
      bit_x(k == n - 1, q);
    end
    pull = 1'b1;
    qw();
    scl = 1'b1;
    qw();
    pull = 1'b0;
  endtask
endmodule // pmr_i2c_master
`default_nettype wire

// ---- dv/pmr_readback_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// port checker for the readback block
module pmr_readback_chk (
  input wire logic       ref_clk,                // system clock
  input wire logic       reset,                  // async reset
  input wire logic       scl_in,                 // serial clock
  input wire logic       sda_oe,                 // data pull-down
  input wire logic       on_off_input_pin,       // on/off pin
  input wire logic       software_switch_off,    // software off
  input wire logic       switch_off_overcurrent, // analog trip
  input wire logic       latch_off_variant,      // latch-off part
  input wire logic       curr_valid,             // current result pulse
  input wire logic       alert_clear_wr,         // clear pulse
  input wire logic       alert_clear_bit,        // clear readback
  input wire logic [7:0] alert_status            // status byte
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_clr; alert_clear_wr ##1 !alert_clear_wr |-> alert_clear_bit ##1 !alert_clear_bit; endproperty
  a_clr: assert property (p_clr) else $error("clear bit did not pulse");
  property p_top; alert_status[7:6] == 2'h0; endproperty
  a_top: assert property (p_top) else $error("status top bits set");
  property p_off; (!on_off_input_pin || software_switch_off) |-> ##[0:4] alert_status[4]; endproperty
  a_off: assert property (p_off) else $error("off status missing");
  property p_on; (on_off_input_pin && !software_switch_off) [*5] |-> !alert_status[4]; endproperty
  a_on: assert property (p_on) else $error("off status while on");
  property p_wipe; alert_clear_wr && !curr_valid |-> ##[1:2] ((alert_status & 8'h2A) == 8'h00); endproperty
  a_wipe: assert property (p_wipe) else $error("latched bits not cleared");
  property p_keep0;
    alert_clear_wr && !curr_valid && !$past(curr_valid) |=> alert_status[0] == $past(alert_status[0]);
  endproperty
  a_keep0: assert property (p_keep0) else $error("clear touched bit 0");
  property p_swoc; (!latch_off_variant && switch_off_overcurrent) [*4] |-> alert_status[2]; endproperty
  a_swoc: assert property (p_swoc) else $error("switch overcurrent not shown");
  property p_hold3; alert_status[3] && !alert_clear_wr && !alert_clear_bit |=> alert_status[3]; endproperty
  a_hold3: assert property (p_hold3) else $error("fail bit dropped");
  property p_hold1; alert_status[1] && !alert_clear_wr && !alert_clear_bit |=> alert_status[1]; endproperty
  a_hold1: assert property (p_hold1) else $error("conversion alert dropped");
  property p_sda; $changed(sda_oe) |-> !scl_in; endproperty
  a_sda: assert property (p_sda) else $error("data moved while clock high");
  c_oc: cover property (alert_status[0]);
  c_clr: cover property (alert_clear_bit);
  c_ack: cover property ($rose(sda_oe));
endmodule // pmr_readback_chk
bind pmr_readback pmr_readback_chk u_chk (.ref_clk(ref_clk), .reset(reset), .scl_in(scl_in), .sda_oe(sda_oe),
  .on_off_input_pin(on_off_input_pin), .software_switch_off(software_switch_off),
  .switch_off_overcurrent(switch_off_overcurrent), .latch_off_variant(latch_off_variant),
  .curr_valid(curr_valid), .alert_clear_wr(alert_clear_wr), .alert_clear_bit(alert_clear_bit),
  .alert_status(alert_status));
`default_nettype wire

// ---- dv/tb_pmr_readback.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_pmr_readback;
  localparam logic [6:0] ADR = 7'h40; // arbitrary bus address
  logic        ref_clk, reset, scl, pull, sda_out, sda_oe, vv, cv, ss, srs, cae, soo, lov;
  logic        sfe, sfae, oip, sso, oae, acw, acb, acked;
  logic [11:0] vc, ic;
  logic [7:0]  thr, ast;
  logic [1:0]  md;
  logic [23:0] got;
  wire         sda;
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  // pulled-up data line
  assign sda = !(sda_oe || pull);
  pmr_readback #(.DEV_ADDR(ADR), .CW(12)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .volt_code(vc), .curr_code(ic), .volt_valid(vv), .curr_valid(cv), .readback_mode(md),
    .single_shot(ss), .status_read_sel(srs), .alert_threshold_reg(thr), .conv_alert_enable(cae),
    .switch_off_overcurrent(soo), .latch_off_variant(lov), .switch_fail_event(sfe),
    .switch_fail_alert_enable(sfae), .on_off_input_pin(oip), .software_switch_off(sso),
    .off_alert_enable(oae), .alert_clear_wr(acw), .alert_clear_bit(acb), .alert_status(ast));
  pmr_i2c_master m (.clk(ref_clk), .sda(sda), .scl(scl), .pull(pull));
  task automatic chk(input logic [24:0] g, input logic [24:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // status read: byte acked, repeated byte refused
  task automatic st(input logic [7:0] e);
    m.xfer(ADR, 2, acked, got);
    chk(acked, 1'b1);
    chk(got, {8'h00, e, e});
    chk({sda_out, ast}, {1'b0, e});
  endtask
  task automatic pcv();
    @(negedge ref_clk) cv = 1'b1;
    @(negedge ref_clk) cv = 1'b0;
  endtask
  task automatic pclr();
    @(negedge ref_clk) acw = 1'b1;
    @(negedge ref_clk) acw = 1'b0;
    chk(acb, 1'b1);
    @(negedge ref_clk);
    chk(acb, 1'b0);
  endtask
  task automatic t_early();
    ss = 1'b1;
    m.xfer(ADR, 1, acked, got);
    chk(acked, 1'b0);
    ss = 1'b0;
    m.xfer(ADR, 3, acked, got);
    chk({acked, got}, {1'b1, 24'h000000});
  endtask
  task automatic t_frames();
    logic [23:0] e[3] = '{24'hAB12C3, 24'h00ABC0, 24'h001230};
    vc = 12'hABC;
    ic = 12'h123;
    @(negedge ref_clk) {vv, cv} = 2'b11;
    @(negedge ref_clk) {vv, cv} = 2'b00;
    ss = 1'b1; // single-shot reads ack once results are in
    for (int k = 0; k < 3; k++) begin
      md = k[1:0];
      m.xfer(ADR, k == 0 ? 3 : 2, acked, got);
      chk({acked, got}, {1'b1, e[k]});
    end
    ss = 1'b0;
    m.xfer(ADR ^ 7'h01, 1, acked, got);
    chk(acked, 1'b0);
  endtask
  task automatic t_status();
    srs = 1'b1;
    {oae, lov, sfae} = 3'b111;
    @(negedge ref_clk) sso = 1'b1;
    @(negedge ref_clk) sfe = 1'b1;
    @(negedge ref_clk) sfe = 1'b0;
    st(8'h3C);
    pclr();
    st(8'h10);
    @(negedge ref_clk) oip = 1'b0;
    repeat (4) @(negedge ref_clk);
    sso = 1'b0;
    st(8'h10);
  endtask
  task automatic t_oc();
    {lov, soo, thr, ic} = {2'b01, 8'h50, 12'h510};
    pcv();
    pcv();
    st(8'h14);
    cae = 1'b1;
    pcv();
    st(8'h17);
    pclr();
    st(8'h15);
  endtask
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    {ref_clk, reset, vv, cv, ss, srs, cae, soo, lov, sfe, sfae, sso, oae, acw} = 14'h1000;
    {oip, thr, md, vc, ic} = {1'b1, 8'hFF, 2'h0, 12'h000, 12'h000};
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    repeat (5) @(negedge ref_clk);
    t_early();
    t_frames();
    t_status();
    t_oc();
    wrap_up();
  end
endmodule // tb_pmr_readback
`default_nettype wire
